// ==== design/siu_pkg.sv ====
// Shared constants and types of the serial interrupt unit
package siu_pkg;
   // Source counts and field widths
   localparam int N_EXT         = 16;
   localparam int N_PAR         = 5;
   localparam int PRI_W         = 4;
   localparam int SLOT_W        = 4;
   localparam int DIV_W         = 3;
   localparam int MODE_SCLK_CYC = 2;
   // Half period of the serial clock in link clocks: 1 .. 7
   localparam logic [DIV_W-1:0] DIV_MIN = 3'h1;
   localparam logic [DIV_W-1:0] DIV_MAX = 3'h7;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_MASK  = 8'h04;
   localparam logic [7:0] ADDR_POL   = 8'h08;
   localparam logic [7:0] ADDR_SENSE = 8'h0c;
   localparam logic [7:0] ADDR_PRI0  = 8'h10;
   localparam logic [7:0] ADDR_PRI1  = 8'h14;
   localparam logic [7:0] ADDR_PRI2  = 8'h18;
   localparam logic [7:0] ADDR_PEND  = 8'h1c;
   localparam logic [7:0] ADDR_VEC   = 8'h20;
   localparam logic [7:0] ADDR_LINES = 8'h24;
   // Control fields
   localparam int CTRL_SER_BIT = 0;
   localparam int CTRL_EN_BIT  = 1;
   localparam int CTRL_DIV_LSB = 4;
   localparam int VEC_VLD_BIT  = 31;
   // Reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0010;
   localparam logic [31:0] MASK_RST  = 32'hffff_ffff;
   localparam logic [31:0] POL_RST   = 32'h000f_0000;
   localparam logic [31:0] SENSE_RST = 32'h0000_0000;
   localparam logic [31:0] PRI_RST   = 32'h0000_0000;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Mode switch pulse sequencer
   typedef enum logic [1:0] {
      MS_IDLE  = 2'h0,
      MS_WAIT  = 2'h1,
      MS_PULSE = 2'h2
   } siu_mode_st_t;
endpackage : siu_pkg

// ==== design/siu_link.sv ====
// Link-clock side: serial clock, frame sync, slot sampling, mode pulse
module siu_link
   import siu_pkg::*;
#(
   parameter int N = N_EXT
)
(
   // Link clock and core reset
   input  wire logic             i_link_clock,
   input  wire logic             i_rst_n,
   // Configuration from the core domain
   input  wire logic             i_serial,
   input  wire logic [DIV_W-1:0] i_div,
   // Multiplexer pins
   input  wire logic             i_sdata,
   output logic                  o_sclk,
   output logic                  o_frame_n,
   output logic                  o_mode_sw,
   // Sampled slot levels, active low
   output logic [N-1:0]          o_lines
);
   logic [1:0]        rst_sync;
   logic              rst_n_l;
   logic              ser_s1, ser_s2, ser_q;
   logic [DIV_W-1:0]  div_s1, div_s2, half, cnt;
   logic              tick, rise, armed;
   logic [SLOT_W-1:0] slot;
   logic [1:0]        pcnt;
   siu_mode_st_t      st;
   logic [7:0]        pw, gap;
   logic              seen;
   logic [DIV_W-1:0]  half_q;

   // Reset release into the link domain
   always_ff @(posedge i_link_clock) begin
      rst_sync <= {rst_sync[0], i_rst_n};
   end
   assign rst_n_l = rst_sync[1];

   // Quasi-static configuration crossing
   always_ff @(posedge i_link_clock) begin
      if (!rst_n_l) begin
         ser_s1 <= 1'b0;
         ser_s2 <= 1'b0;
         div_s1 <= DIV_MIN;
         div_s2 <= DIV_MIN;
      end else begin
         ser_s1 <= i_serial;
         ser_s2 <= ser_s1;
         div_s1 <= i_div;
         div_s2 <= div_s1;
      end
   end

   // Clamp divider into the legal range
   assign half = (div_s2 < DIV_MIN) ? DIV_MIN : div_s2;
   assign tick = (cnt == half - DIV_MIN);
   assign rise = tick & ~o_sclk;

   // Serial clock divider
   always_ff @(posedge i_link_clock) begin
      if (!rst_n_l) begin
         cnt    <= '0;
         o_sclk <= 1'b0;
      end else if (tick) begin
         cnt    <= '0;
         o_sclk <= ~o_sclk;
      end else begin
         cnt    <= cnt + DIV_MIN;
      end
   end

   // Frame sync and slot capture on the rising serial clock
   always_ff @(posedge i_link_clock) begin
      if (!rst_n_l || !ser_s2) begin
         armed     <= 1'b0;
         slot      <= '0;
         o_frame_n <= 1'b1;
         o_lines   <= '1;
      end else if (rise) begin
         if (!armed) begin
            armed     <= 1'b1;
            o_frame_n <= 1'b0;
            slot      <= '0;
         end else begin
            o_lines[slot] <= i_sdata;
            o_frame_n     <= (slot != SLOT_W'(N - 1));
            slot          <= (slot == SLOT_W'(N - 1)) ? '0 : slot + 1'b1;
         end
      end
   end

   // Mode switch pulse on parallel to serial change
   always_ff @(posedge i_link_clock) begin
      if (!rst_n_l) begin
         st        <= MS_IDLE;
         ser_q     <= 1'b0;
         pcnt      <= '0;
         o_mode_sw <= 1'b0;
      end else begin
         ser_q <= ser_s2;
         case (st)
            MS_IDLE: if (ser_s2 && !ser_q) st <= MS_WAIT;
            MS_WAIT: if (rise) begin
               st        <= MS_PULSE;
               pcnt      <= '0;
               o_mode_sw <= 1'b1;
            end
            MS_PULSE: if (rise) begin
               if (pcnt == 2'(MODE_SCLK_CYC - 1)) begin
                  st        <= MS_IDLE;
                  o_mode_sw <= 1'b0;
               end else begin
                  pcnt <= pcnt + 2'h1;
               end
            end
            default: st <= MS_IDLE;
         endcase
      end
   end

   // Helper counters for the checks below
   always_ff @(posedge i_link_clock) begin
      if (!rst_n_l) begin
         pw   <= '0;
         gap  <= '0;
         seen <= 1'b0;
         half_q <= DIV_MIN;
      end else begin
         pw   <= o_mode_sw ? pw + 8'h1 : 8'h0;
         gap  <= rise ? 8'h0 : gap + 8'h1;
         half_q <= half;
         // A divider change leaves one odd period: wait for a fresh rise
         seen <= (seen | rise) & (half == half_q);
      end
   end

   mode_pulse_a: assert property (@(posedge i_link_clock)
      disable iff (!rst_n_l)
      $fell(o_mode_sw) |-> pw == 8'(MODE_SCLK_CYC * 2 * int'(half)))
      else $error("mode pulse not two serial clocks");
   mode_cause_a: assert property (@(posedge i_link_clock)
      disable iff (!rst_n_l)
      $rose(o_mode_sw) |-> ser_s2 && st == MS_PULSE)
      else $error("mode pulse without serial mode");
   sclk_ratio_a: assert property (@(posedge i_link_clock)
      disable iff (!rst_n_l)
      rise && seen && $stable(half) |-> gap == 8'(2 * int'(half) - 1))
      else $error("serial clock period wrong");
   sample_edge_a: assert property (@(posedge i_link_clock)
      disable iff (!rst_n_l)
      $changed(o_lines) && ser_s2 && $past(ser_s2) |-> $rose(o_sclk))
      else $error("slot sampled off the rising edge");
   cover_pulse_c: cover property (@(posedge i_link_clock)
      disable iff (!rst_n_l) $fell(o_mode_sw));
endmodule : siu_link

// ==== design/siu_top.sv ====
// Serial interrupt unit: bus registers, source gathering, priority
// Functional notes
// - Five parallel or sixteen serial external inputs
// - Serial slots drive external interrupt lines
// - Processor interrupt only while output enabled
// - Per-source mask, priority, polarity, edge/level
// - Mode pulse two serial clocks on entry
// - Serial data sampled on rising serial clock
// - Serial clock is link clock over 2..14
module siu_top
   import siu_pkg::*;
#(
   parameter int N_INT = 4
)
(
   // Core clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   // AXI4-Lite write address and data
   input  wire logic             i_axi_awvalid,
   output logic                  o_axi_awready,
   input  wire logic [7:0]       i_axi_awaddr,
   input  wire logic             i_axi_wvalid,
   output logic                  o_axi_wready,
   input  wire logic [31:0]      i_axi_wdata,
   input  wire logic [3:0]       i_axi_wstrb,
   // AXI4-Lite write response
   output logic                  o_axi_bvalid,
   input  wire logic             i_axi_bready,
   output logic [1:0]            o_axi_bresp,
   // AXI4-Lite read
   input  wire logic             i_axi_arvalid,
   output logic                  o_axi_arready,
   input  wire logic [7:0]       i_axi_araddr,
   output logic                  o_axi_rvalid,
   input  wire logic             i_axi_rready,
   output logic [31:0]           o_axi_rdata,
   output logic [1:0]            o_axi_rresp,
   // Link clock and multiplexer pins
   input  wire logic             i_link_clock,
   output logic                  o_sclk,
   output logic                  o_frame_n,
   output logic                  o_mode_sw,
   input  wire logic             i_sdata,
   // Parallel external and internal sources
   input  wire logic [N_PAR-1:0] i_ext_irq_n,
   input  wire logic [N_INT-1:0] i_int_irq,
   // Processor interrupt
   output logic                  o_irq
);
   localparam int N_SRC = N_EXT + N_INT;
   localparam int IDX_W = $clog2(N_SRC);

   logic [31:0]      ctrl, mask, pol, sense;
   logic [31:0]      pri_w [3];
   logic [N_PAR-1:0] par_s1, par_s2;
   logic [N_EXT-1:0] w_lines, lines_s1, lines_s2, ext_lvl_n;
   logic [N_SRC-1:0] raw, act, act_q, pend, elig, clr;
   logic             aw_hold, w_hold;
   logic [7:0]       aw_addr;
   logic [31:0]      w_data;
   logic [3:0]       w_strb;
   logic             do_wr, wr_ok;
   logic [IDX_W-1:0] best_idx;
   logic             best_vld;
   logic [31:0]      rd_val;
   logic             rd_ok;

   // Byte-lane merge of a write into a register
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction : merge

   // Priority field of one source
   function automatic logic [PRI_W-1:0] pri_of(input int k,
                                              input logic [31:0] w0,
                                              input logic [31:0] w1,
                                              input logic [31:0] w2);
      logic [31:0] w;
      w = (k < 8) ? w0 : (k < 16) ? w1 : w2;
      return w[(k % 8) * PRI_W +: PRI_W];
   endfunction : pri_of

   // Link domain logic
   siu_link #(
      .N (N_EXT)
   ) u_link (
      .i_link_clock (i_link_clock),
      .i_rst_n      (i_rst_n),
      .i_serial     (ctrl[CTRL_SER_BIT]),
      .i_div        (ctrl[CTRL_DIV_LSB +: DIV_W]),
      .i_sdata      (i_sdata),
      .o_sclk       (o_sclk),
      .o_frame_n    (o_frame_n),
      .o_mode_sw    (o_mode_sw),
      .o_lines      (w_lines)
   );

   // Two-flop synchronisers for pins and link-domain lines
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         par_s1   <= '1;
         par_s2   <= '1;
         lines_s1 <= '1;
         lines_s2 <= '1;
      end else begin
         par_s1   <= i_ext_irq_n;
         par_s2   <= par_s1;
         lines_s1 <= w_lines;
         lines_s2 <= lines_s1;
      end
   end

   // External level per mode; idle sources read high
   always_comb begin
      for (int k = 0; k < N_EXT; k++) begin
         if (ctrl[CTRL_SER_BIT]) begin
            ext_lvl_n[k] = lines_s2[k];
         end else if (k < N_PAR) begin
            ext_lvl_n[k] = par_s2[k];
         end else begin
            ext_lvl_n[k] = 1'b1;
         end
      end
   end

   // Polarity applied to the raw source levels
   assign raw = {i_int_irq, ext_lvl_n};
   assign act = raw ~^ pol[N_SRC-1:0];

   // Pending state: level follows, edge latches until cleared
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         act_q <= '0;
         pend  <= '0;
      end else begin
         act_q <= act;
         for (int k = 0; k < N_SRC; k++) begin
            if (sense[k]) begin
               pend[k] <= (pend[k] & ~clr[k]) | (act[k] & ~act_q[k]);
            end else begin
               pend[k] <= act[k];
            end
         end
      end
   end

   // Eligible sources: pending, unmasked, nonzero priority
   always_comb begin
      for (int k = 0; k < N_SRC; k++) begin
         elig[k] = pend[k] & ~mask[k] &
                   (pri_of(k, pri_w[0], pri_w[1], pri_w[2]) != '0);
      end
   end

   // Highest priority wins, lower index on a tie
   always_comb begin
      logic [PRI_W-1:0] bp;
      bp       = '0;
      best_idx = '0;
      best_vld = 1'b0;
      for (int k = 0; k < N_SRC; k++) begin
         if (elig[k] && pri_of(k, pri_w[0], pri_w[1], pri_w[2]) > bp) begin
            bp       = pri_of(k, pri_w[0], pri_w[1], pri_w[2]);
            best_idx = IDX_W'(k);
            best_vld = 1'b1;
         end
      end
   end

   // Processor interrupt, gated by the output enable
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= best_vld & ctrl[CTRL_EN_BIT];
      end
   end

   // Write channel acceptance, either order
   assign o_axi_awready = !aw_hold && !o_axi_bvalid;
   assign o_axi_wready  = !w_hold && !o_axi_bvalid;
   assign do_wr         = aw_hold && w_hold && !o_axi_bvalid;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
      end else begin
         if (i_axi_awvalid && o_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= i_axi_awaddr;
         end else if (do_wr) begin
            aw_hold <= 1'b0;
         end
         if (i_axi_wvalid && o_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= i_axi_wdata;
            w_strb <= i_axi_wstrb;
         end else if (do_wr) begin
            w_hold <= 1'b0;
         end
      end
   end

   // Address decode of writes
   always_comb begin
      wr_ok = 1'b1;
      clr   = '0;
      case ({aw_addr[7:2], 2'h0})
         ADDR_CTRL, ADDR_MASK, ADDR_POL, ADDR_SENSE,
         ADDR_PRI0, ADDR_PRI1, ADDR_PRI2: wr_ok = 1'b1;
         ADDR_PEND: begin
            clr = do_wr ? N_SRC'(merge('0, w_data, w_strb)) : '0;
         end
         default: wr_ok = 1'b0;
      endcase
   end

   // Register writes
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ctrl     <= CTRL_RST;
         mask     <= MASK_RST;
         pol      <= POL_RST;
         sense    <= SENSE_RST;
         pri_w[0] <= PRI_RST;
         pri_w[1] <= PRI_RST;
         pri_w[2] <= PRI_RST;
      end else if (do_wr) begin
         case ({aw_addr[7:2], 2'h0})
            ADDR_CTRL:  ctrl     <= merge(ctrl, w_data, w_strb);
            ADDR_MASK:  mask     <= merge(mask, w_data, w_strb);
            ADDR_POL:   pol      <= merge(pol, w_data, w_strb);
            ADDR_SENSE: sense    <= merge(sense, w_data, w_strb);
            ADDR_PRI0:  pri_w[0] <= merge(pri_w[0], w_data, w_strb);
            ADDR_PRI1:  pri_w[1] <= merge(pri_w[1], w_data, w_strb);
            ADDR_PRI2:  pri_w[2] <= merge(pri_w[2], w_data, w_strb);
            default:    ctrl     <= ctrl;
         endcase
      end
   end

   // Write response
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_axi_bvalid <= 1'b0;
         o_axi_bresp  <= RESP_OKAY;
      end else if (do_wr) begin
         o_axi_bvalid <= 1'b1;
         o_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_axi_bready) begin
         o_axi_bvalid <= 1'b0;
      end
   end

   // Read decode
   always_comb begin
      rd_ok  = 1'b1;
      rd_val = '0;
      case ({i_axi_araddr[7:2], 2'h0})
         ADDR_CTRL:  rd_val = ctrl;
         ADDR_MASK:  rd_val = mask;
         ADDR_POL:   rd_val = pol;
         ADDR_SENSE: rd_val = sense;
         ADDR_PRI0:  rd_val = pri_w[0];
         ADDR_PRI1:  rd_val = pri_w[1];
         ADDR_PRI2:  rd_val = pri_w[2];
         ADDR_PEND:  rd_val = 32'(pend);
         ADDR_VEC: begin
            rd_val              = 32'(best_idx);
            rd_val[VEC_VLD_BIT] = best_vld;
         end
         ADDR_LINES: rd_val = {11'h0, par_s2, ext_lvl_n};
         default:    rd_ok  = 1'b0;
      endcase
   end

   // Read channel: answer one cycle after the address
   assign o_axi_arready = !o_axi_rvalid;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_axi_rvalid <= 1'b0;
         o_axi_rdata  <= '0;
         o_axi_rresp  <= RESP_OKAY;
      end else if (i_axi_arvalid && o_axi_arready) begin
         o_axi_rvalid <= 1'b1;
         o_axi_rdata  <= rd_val;
         o_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_axi_rready) begin
         o_axi_rvalid <= 1'b0;
      end
   end

   // Checks on the core domain
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   par_only_a: assert property (
      !$past(ctrl[CTRL_SER_BIT]) && $past(sense[N_EXT-1:N_PAR]) == '0 &&
      $past(pol[N_EXT-1:N_PAR]) == '0 |-> pend[N_EXT-1:N_PAR] == '0)
      else $error("idle parallel source pending");
   ser_demux_a: assert property (
      ctrl[CTRL_SER_BIT] |-> ext_lvl_n == $past(w_lines, 2))
      else $error("serial line not forwarded");
   irq_gate_a: assert property (
      o_irq |-> $past(ctrl[CTRL_EN_BIT]) && $past(best_vld))
      else $error("interrupt while disabled");
   irq_cause_a: assert property (
      ctrl[CTRL_EN_BIT] && best_vld |=> o_irq)
      else $error("interrupt not raised");
   mask_all_a: assert property (
      (mask[N_SRC-1:0] == '1) [*2] |-> !o_irq)
      else $error("masked source reached output");
   level_follow_a: assert property (
      sense[N_SRC-1:0] == '0 |=> pend == $past(act))
      else $error("level source not followed");
   edge_hold_a: assert property (
      (sense[N_EXT] && pend[N_EXT] && !clr[N_EXT]) |=> pend[N_EXT])
      else $error("edge pending lost");
   bresp_hold_a: assert property (
      o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (
      o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
      else $error("read data dropped");

   ser_mode_c: cover property ($rose(ctrl[CTRL_SER_BIT]));
   irq_rise_c: cover property ($rose(o_irq));
   edge_clr_c: cover property (sense[N_EXT] && $fell(pend[N_EXT]));
   bad_addr_c: cover property (o_axi_rvalid && o_axi_rresp == RESP_SLVERR);
endmodule : siu_top

// ==== design/siu_top_end.sv ====
// Holds no logic; the unit lives in siu_top and siu_link

// ==== verif/siu_mux_model.sv ====
// Behavioural external serial multiplexer facing the unit
module siu_mux_model
   import siu_pkg::*;
(
   // Serial link from the unit
   input  wire logic             i_sclk,
   input  wire logic             i_frame_n,
   // External requests, active low
   input  wire logic [N_EXT-1:0] i_irq_n,
   // Slot data back to the unit
   output logic                  o_sdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [SLOT_W-1:0] slot = '0;
   // Falling edge moves the slot, so data settles before the unit samples
   always @(negedge i_sclk) begin
      if (!i_frame_n) slot <= '0;
      else slot <= slot + 4'h1;
   end
   // Selected request; high means nothing pending
   assign o_sdata = i_irq_n[slot];
endmodule : siu_mux_model

// ==== verif/serial_interrupt_expansion_tb.sv ====
// Self-checking bench: unit, multiplexer model and bus master
`define chk(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %0t got %h want %h", $time, g, e); end end
module serial_interrupt_expansion_tb
   import siu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Pins, bus and bench state
   logic i_clock = 1'b0, i_link_clock = 1'b0, i_rst_n = 1'b0;
   logic i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_arvalid = 1'b0;
   logic [7:0] i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00;
   logic [31:0] i_axi_wdata = 32'h0;
   logic [N_PAR-1:0] i_ext_irq_n = '1;
   logic [3:0] i_int_irq = 4'h0;
   logic [N_EXT-1:0] mux_n = '1;
   logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready;
   logic o_axi_rvalid, o_sclk, o_frame_n, o_mode_sw, i_sdata, o_irq;
   logic [1:0] o_axi_bresp, o_axi_rresp;
   logic [31:0] o_axi_rdata;
   logic sclk_d = 1'b0;
   int bad_count = 0, checked = 0, lk = 0, last_rise = 0, period = 0;
   int ms_cnt = 0, div, pw [3];

   // Design and far-side model
   siu_top dut (
      .i_clock, .i_rst_n, .i_axi_awvalid, .o_axi_awready, .i_axi_awaddr,
      .i_axi_wvalid, .o_axi_wready, .i_axi_wdata, .i_axi_wstrb(4'hf),
      .o_axi_bvalid, .i_axi_bready(1'b1), .o_axi_bresp, .i_axi_arvalid,
      .o_axi_arready, .i_axi_araddr, .o_axi_rvalid, .i_axi_rready(1'b1),
      .o_axi_rdata, .o_axi_rresp, .i_link_clock, .o_sclk, .o_frame_n,
      .o_mode_sw, .i_sdata, .i_ext_irq_n, .i_int_irq, .o_irq
   );
   siu_mux_model mux (
      .i_sclk(o_sclk), .i_frame_n(o_frame_n),
      .i_irq_n(mux_n), .o_sdata(i_sdata)
   );

   // Core clock and an unrelated link clock
   always #12.5 i_clock = ~i_clock;
   initial begin
      #1.7;
      forever #3 i_link_clock = ~i_link_clock;
   end

   // Serial clock period and mode pulse length in link clocks
   always @(negedge i_link_clock) begin
      lk++;
      if (o_sclk === 1'b1 && !sclk_d) begin
         period = lk - last_rise;
         last_rise = lk;
      end
      sclk_d = (o_sclk === 1'b1);
      if (o_mode_sw === 1'b1) ms_cnt++;
   end

   // One bus write, checking its response
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, sa, sw;
      ta = 1'b0;
      tw = 1'b0;
      i_axi_awaddr <= a;
      i_axi_wdata <= d;
      i_axi_awvalid <= 1'b1;
      i_axi_wvalid <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge i_clock);
         sa = !ta && o_axi_awready;
         sw = !tw && o_axi_wready;
         @(posedge i_clock);
         if (sa) i_axi_awvalid <= 1'b0;
         if (sw) i_axi_wvalid <= 1'b0;
         ta |= sa;
         tw |= sw;
      end
      do @(negedge i_clock); while (o_axi_bvalid !== 1'b1);
      `chk(o_axi_bresp, (a > ADDR_PEND) ? RESP_SLVERR : RESP_OKAY)
      @(posedge i_clock);
   endtask : wr

   // One bus read, comparing the masked word and the response
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      logic        t;
      i_axi_araddr <= a;
      i_axi_arvalid <= 1'b1;
      t = 1'b0;
      while (!t) begin
         @(negedge i_clock);
         t = o_axi_arready;
         @(posedge i_clock);
         if (t) i_axi_arvalid <= 1'b0;
      end
      t = 1'b0;
      while (!t) begin
         @(negedge i_clock);
         t = o_axi_rvalid;
         d = o_axi_rdata;
         r = o_axi_rresp;
         @(posedge i_clock);
      end
      `chk(d & m, e)
      `chk(r, (a > ADDR_LINES) ? RESP_SLVERR : RESP_OKAY)
   endtask : rd_chk

   // Reference choice: highest priority, lowest index on ties
   function automatic logic [31:0] best_vec(input int act, input int msk);
      int b, bp, p;
      b = 0;
      bp = 0;
      for (int k = 0; k < 20; k++) begin
         p = (pw[k / 8] >> ((k % 8) * 4)) & 15;
         if (act[k] && !msk[k] && p > bp) begin
            bp = p;
            b = k;
         end
      end
      return (bp > 0) ? (32'h8000_0000 | b) : 32'h0;
   endfunction : best_vec

   // Verdict and end of run
   task automatic finish_test();
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      logic [31:0] e, ctl;
      int          msk, act, pl;
      void'($urandom(32'h593e));
      repeat (16) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(posedge i_clock);
      // Reset values and an unmapped place
      rd_chk(ADDR_CTRL, '1, CTRL_RST);
      rd_chk(ADDR_MASK, '1, MASK_RST);
      rd_chk(ADDR_POL, '1, POL_RST);
      rd_chk(ADDR_SENSE, '1, SENSE_RST);
      rd_chk(ADDR_PRI0, '1, PRI_RST);
      rd_chk(8'h40, '1, 32'h0);
      wr(8'h40, 32'h1);
      // Parallel mode: pins reach the lines, serial slots stay idle
      i_ext_irq_n <= 5'($urandom);
      repeat (20) @(posedge i_clock);
      e = {11'h0, i_ext_irq_n, 11'h7ff, i_ext_irq_n};
      rd_chk(ADDR_LINES, 32'h1f_ffff, e);
      `chk(ms_cnt, 0)
      // Divider first, then switch to serial mode
      div = $urandom_range(7, 1);
      ctl = 32'(div) << CTRL_DIV_LSB;
      wr(ADDR_CTRL, ctl);
      repeat (10) @(posedge i_clock);
      ctl |= 32'h1 << CTRL_SER_BIT;
      wr(ADDR_CTRL, ctl);
      repeat (150) @(posedge i_clock);
      `chk(ms_cnt, 4 * div)
      `chk(period, 2 * div)
      // Random requests, masks and priorities; output enable toggled
      for (int i = 0; i < 4; i++) begin
         mux_n <= 16'($urandom);
         i_int_irq <= 4'($urandom);
         msk = $urandom;
         pl = $urandom;
         foreach (pw[j]) pw[j] = $urandom;
         pw[2] = pw[2] & 32'hffff;
         wr(ADDR_MASK, msk);
         wr(ADDR_POL, pl);
         for (int j = 0; j < 3; j++) wr(ADDR_PRI0 + 8'(4 * j), pw[j]);
         wr(ADDR_CTRL, ctl | (32'(i[0]) << CTRL_EN_BIT));
         repeat (150) @(posedge i_clock);
         act = ~({i_int_irq, mux_n} ^ pl);
         e = best_vec(act, msk);
         rd_chk(ADDR_LINES, 32'hffff, 32'(mux_n));
         rd_chk(ADDR_VEC, 32'h8000_0000, e & 32'h8000_0000);
         if (e[31]) rd_chk(ADDR_VEC, 32'h1f, e & 32'h1f);
         @(negedge i_clock);
         `chk(o_irq, e[31] & i[0])
         @(posedge i_clock);
      end
      // Edge sensing on the first internal source, write-one clear
      i_int_irq <= 4'h0;
      wr(ADDR_POL, POL_RST);
      wr(ADDR_SENSE, 32'h1_0000);
      wr(ADDR_PEND, 32'h1_0000);
      i_int_irq <= 4'h1;
      repeat (3) @(posedge i_clock);
      i_int_irq <= 4'h0;
      repeat (3) @(posedge i_clock);
      rd_chk(ADDR_PEND, 32'h1_0000, 32'h1_0000);
      wr(ADDR_PEND, 32'h1_0000);
      rd_chk(ADDR_PEND, 32'h1_0000, 32'h0);
      finish_test();
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge i_clock);
      bad_count++;
      finish_test();
   end
endmodule : serial_interrupt_expansion_tb
